// >>> logic/cells_map.svh
/*
  register offsets, field positions, reset values and timing counts of the
  safety logic cell block; assumes a 40 MHz aclk and an 8 ms processing cycle
*/
`ifndef CELLS_MAP_SVH
`define CELLS_MAP_SVH
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_AND_MASK 8'h04
`define OFS_OR_MASK 8'h08
`define OFS_ROUTE_CELL 8'h0c
`define OFS_ROUTE_OUT 8'h10
`define OFS_PICKUP 8'h14
`define OFS_DROPOUT 8'h18
`define OFS_TIMER_DELAY 8'h1c
`define OFS_STATUS 8'h20
// control fields
`define CTRL_RELAY_RED 0
`define CTRL_HILO_RED 1
`define CTRL_HILO_LOW 2
`define CTRL_FB_EN 3
`define CTRL_TMR_DROPOUT 4
`define CTRL_FB_CH_LO 5
`define CTRL_FB_CH_HI 6
// signal pool positions
`define POOL_CONST1 4
`define POOL_AND 5
`define POOL_OR 6
`define POOL_XOR 7
`define POOL_NOT 8
`define POOL_RS 9
`define POOL_TIMER 10
`define POOL_MON_OK 11
// reset values
`define RST_CTRL 7'h00
`define RST_MASK 12'h000
`define RST_ROUTE_CELL 24'h000000
`define RST_ROUTE_OUT 12'h000
`define RST_WINDOW 9'h001
`define RST_TIMER 22'h000001
// timing
`define CLK_PERIOD_NS 25
`define PROC_CYCLE_MS 8
`define WINDOW_MIN_MS 8
`define WINDOW_MAX_MS 3000
`define TIMER_MAX_MS 31999992
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// >>> logic/cells_pkg.sv
/*
  types shared by the safety logic cell modules; assumes cells_map.svh
  supplies every number
*/
package cells_pkg;
  typedef enum logic [2:0] {
    MON_OFF = 3'b000,
    MON_OPENING = 3'b001,
    MON_ON = 3'b010,
    MON_CLOSING = 3'b011,
    MON_FAULT = 3'b100
  } mon_state_t;
  typedef enum logic {
    TMR_PICKUP = 1'b0,
    TMR_DROPOUT = 1'b1
  } tmr_mode_t;
endpackage : cells_pkg

// >>> logic/delay_timer.sv
/*
  pickup or dropout delayed timer cell, advanced on the processing tick;
  assumes tick is a one-cycle pulse on aclk and delay is at least 1
*/
`timescale 1ns/1ps
`include "cells_map.svh"
module delay_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire cells_pkg::tmr_mode_t mode,
  input wire logic [21:0] delay,
  input wire logic trig,
  output logic out
);
  typedef struct packed {
    logic trig_d;
    logic [21:0] cnt;
    logic out;
  } tmr_st_t;
  tmr_st_t st_ff;
  tmr_st_t nxt_st;
  assign out = st_ff.out;
  // one evaluation per processing tick
  always_comb
  begin
    nxt_st = st_ff;
    if (tick)
    begin
      nxt_st.trig_d = trig;
      if (!trig)
      begin
        nxt_st.out = 1'b0;
        nxt_st.cnt = 22'h000000;
      end
      else if (!st_ff.trig_d)
      begin
        nxt_st.cnt = (delay == 22'h000000) ? 22'h000001 : delay;
        nxt_st.out = (mode == cells_pkg::TMR_DROPOUT);
      end
      else if (st_ff.cnt == 22'h000001)
      begin
        nxt_st.cnt = 22'h000000;
        nxt_st.out = (mode == cells_pkg::TMR_PICKUP);
      end
      else if (st_ff.cnt != 22'h000000)
        nxt_st.cnt = st_ff.cnt - 22'h000001;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_pickup_low;
    (tick && !trig) |=> !out;
  endproperty
  a_pickup_low: assert property (p_pickup_low) else $error("timer out high with low input");
  property p_dropout_rise;
    (tick && trig && !st_ff.trig_d && mode == cells_pkg::TMR_DROPOUT) |=> out;
  endproperty
  a_dropout_rise: assert property (p_dropout_rise) else $error("dropout timer missed rise");
endmodule : delay_timer

// >>> logic/contact_monitor.sv
/*
  contact feedback monitor: checks the series feedback loop against the
  monitored output with pickup and dropout windows counted in ticks;
  assumes loop_closed is already synchronised to aclk
*/
`timescale 1ns/1ps
module contact_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic enable,
  input wire logic out_on,
  input wire logic loop_closed,
  input wire logic [8:0] pickup,
  input wire logic [8:0] dropout,
  output logic ok
);
  typedef struct packed {
    cells_pkg::mon_state_t state;
    logic [8:0] cnt;
    logic ok;
  } mon_st_t;
  mon_st_t st_ff;
  mon_st_t nxt_st;
  assign ok = st_ff.ok;
  // window sequencer, one step per tick; a fault holds until disabled
  always_comb
  begin
    nxt_st = st_ff;
    if (tick)
    begin
      if (!enable)
      begin
        nxt_st.state = cells_pkg::MON_OFF;
        nxt_st.cnt = 9'h000;
      end
      else
      begin
        unique case (st_ff.state)
          cells_pkg::MON_OFF:
            if (out_on)
            begin
              nxt_st.state = cells_pkg::MON_OPENING;
              nxt_st.cnt = pickup;
            end
            else if (!loop_closed)
              nxt_st.state = cells_pkg::MON_FAULT;
          cells_pkg::MON_OPENING:
            if (!out_on)
            begin
              nxt_st.state = cells_pkg::MON_CLOSING;
              nxt_st.cnt = dropout;
            end
            else if (!loop_closed)
              nxt_st.state = cells_pkg::MON_ON;
            else if (st_ff.cnt <= 9'h001)
              nxt_st.state = cells_pkg::MON_FAULT;
            else
              nxt_st.cnt = st_ff.cnt - 9'h001;
          cells_pkg::MON_ON:
            if (!out_on)
            begin
              nxt_st.state = cells_pkg::MON_CLOSING;
              nxt_st.cnt = dropout;
            end
            else if (loop_closed)
              nxt_st.state = cells_pkg::MON_FAULT;
          cells_pkg::MON_CLOSING:
            if (out_on)
            begin
              nxt_st.state = cells_pkg::MON_OPENING;
              nxt_st.cnt = pickup;
            end
            else if (loop_closed)
              nxt_st.state = cells_pkg::MON_OFF;
            else if (st_ff.cnt <= 9'h001)
              nxt_st.state = cells_pkg::MON_FAULT;
            else
              nxt_st.cnt = st_ff.cnt - 9'h001;
          cells_pkg::MON_FAULT:
            nxt_st.state = cells_pkg::MON_FAULT;
          default:
            nxt_st.state = cells_pkg::MON_FAULT;
        endcase
      end
      nxt_st.ok = (nxt_st.state != cells_pkg::MON_FAULT);
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_ff <= '{state: cells_pkg::MON_OFF, cnt: 9'h000, ok: 1'b1};
    else
      st_ff <= nxt_st;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_disabled_ok;
    (tick && !enable) |=> ok;
  endproperty
  a_disabled_ok: assert property (p_disabled_ok) else $error("monitor fault while disabled");
  property p_closed_when_on;
    (tick && enable && st_ff.state == cells_pkg::MON_ON && out_on && loop_closed) |=> !ok;
  endproperty
  a_closed_when_on: assert property (p_closed_when_on) else $error("closed loop with output on missed");
  property p_pickup_expire;
    (tick && enable && st_ff.state == cells_pkg::MON_OPENING && out_on && loop_closed && st_ff.cnt == 9'h001)
      |=> !ok;
  endproperty
  a_pickup_expire: assert property (p_pickup_expire) else $error("pickup window expiry missed");
endmodule : contact_monitor

// >>> logic/safety_logic_cells.sv
/*
  safety logic cells with output elements and contact feedback monitor,
  configured over AXI4-Lite; assumes digital_in comes from pins and is
  asynchronous to aclk, and that aclk runs at 40 MHz
*/
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "cells_map.svh"
// How it works
// - each output element switches from one logic value of the network.
// - single relay mode: both relays follow their own drive signal.
// - redundant relay mode: both relays follow one signal together.
// - high-low output acts as high or low side singly, both when redundant.
// - monitor expects the loop closed while output off, open while on.
// - monitor runs only when enabled and reads a selected digital input.
// - pickup window programmable from 8 ms to 3000 ms.
// - dropout window programmable from 8 ms to 3000 ms.
// - conjunction of up to five connected inputs; the mask here admits any of the twelve pool signals.
// - disjunction of up to five connected inputs; the mask here admits any of the twelve pool signals.
// - exclusive-or of exactly two inputs.
// - inverter outputs the complement of its input every cycle.
// - storage cell holds zero after initialisation.
// - rising set makes the storage cell one until reset rises.
// - set and reset both high give zero.
// - timer delay 8 ms to 31999992 ms, started on an input edge.
// - timer delays are whole 8 ms cycles, counted once per cycle.
// - pickup timer rises after the delay, drops at once on input fall.
// - dropout timer rises at once, drops at expiry or input fall.
// - constant cell drives one permanently.
// - monitor result cell is one while feedback checking is fault-free.
module safety_logic_cells #(
  parameter int TICK_CYCLES = (`PROC_CYCLE_MS * 1000000) / `CLK_PERIOD_NS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] digital_in,
  output logic first_relay,
  output logic second_relay,
  output logic high_side_switch,
  output logic low_side_switch,
  output logic monitor_fault
);
  localparam int DIV_W = $clog2(TICK_CYCLES + 1);
  localparam int WIN_MIN = `WINDOW_MIN_MS / `PROC_CYCLE_MS;
  localparam int WIN_MAX = `WINDOW_MAX_MS / `PROC_CYCLE_MS;
  localparam int TMR_MAX = `TIMER_MAX_MS / `PROC_CYCLE_MS;
  typedef struct packed {
    logic [3:0] din_m;
    logic [3:0] din_s;
    logic [DIV_W-1:0] div;
    logic tick;
    logic [6:0] ctrl;
    logic [11:0] and_mask;
    logic [11:0] or_mask;
    logic [23:0] route_cell;
    logic [11:0] route_out;
    logic [8:0] pickup;
    logic [8:0] dropout;
    logic [21:0] tdelay;
    logic and_q;
    logic or_q;
    logic xor_q;
    logic not_q;
    logic rs_q;
    logic set_d;
    logic rst_d;
    logic r1;
    logic r2;
    logic hs;
    logic ls;
    logic fault;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awrdy;
    logic wrdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } top_st_t;
  top_st_t st_ff;
  top_st_t nxt_st;
  logic [11:0] pool;
  logic timer_q;
  logic mon_ok;

  // merge a write word into a register under the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[8*i +: 8] = wd[8*i +: 8];
    return res;
  endfunction : merge

  // keep a programmed count inside its legal range
  function automatic logic [21:0] clamp(input logic [31:0] v, input int lo, input int hi);
    logic [21:0] res;
    if (v < 32'(lo))
      res = 22'(lo);
    else if (v > 32'(hi))
      res = 22'(hi);
    else
      res = v[21:0];
    return res;
  endfunction : clamp

  // signal pool read by every cell; registered values break loops
  always_comb
  begin
    pool = {mon_ok, timer_q, st_ff.rs_q, st_ff.not_q, st_ff.xor_q, st_ff.or_q, st_ff.and_q,
      1'b1, st_ff.din_s};
  end

  delay_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(st_ff.tick),
    .mode(cells_pkg::tmr_mode_t'(st_ff.ctrl[`CTRL_TMR_DROPOUT])),
    .delay(st_ff.tdelay),
    .trig(pool[st_ff.route_cell[23:20]]),
    .out(timer_q)
  );

  contact_monitor u_monitor (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(st_ff.tick),
    .enable(st_ff.ctrl[`CTRL_FB_EN]),
    .out_on(st_ff.hs | st_ff.ls),
    .loop_closed(st_ff.din_s[st_ff.ctrl[`CTRL_FB_CH_HI:`CTRL_FB_CH_LO]]),
    .pickup(st_ff.pickup),
    .dropout(st_ff.dropout),
    .ok(mon_ok)
  );

  always_comb
  begin
    logic [31:0] wd;
    logic [7:0] wa;
    logic wr_ok;
    logic drv;
    wd = 32'h00000000;
    wa = 8'h00;
    wr_ok = 1'b0;
    drv = 1'b0;
    nxt_st = st_ff;
    // pins pass two flops; the tick divider paces the whole network
    nxt_st.din_m = digital_in;
    nxt_st.din_s = st_ff.din_m;
    nxt_st.tick = (st_ff.div == DIV_W'(TICK_CYCLES - 1));
    nxt_st.div = nxt_st.tick ? '0 : st_ff.div + DIV_W'(1);
    // network evaluated once per processing cycle
    if (st_ff.tick)
    begin
      nxt_st.and_q = &(pool | ~st_ff.and_mask);
      nxt_st.or_q = |(pool & st_ff.or_mask);
      nxt_st.xor_q = pool[st_ff.route_cell[3:0]] ^ pool[st_ff.route_cell[7:4]];
      nxt_st.not_q = ~pool[st_ff.route_cell[11:8]];
      nxt_st.set_d = pool[st_ff.route_cell[15:12]];
      nxt_st.rst_d = pool[st_ff.route_cell[19:16]];
      if (nxt_st.set_d && nxt_st.rst_d)
        nxt_st.rs_q = 1'b0;
      else if (nxt_st.rst_d && !st_ff.rst_d)
        nxt_st.rs_q = 1'b0;
      else if (nxt_st.set_d && !st_ff.set_d)
        nxt_st.rs_q = 1'b1;
      // output elements
      nxt_st.r1 = pool[st_ff.route_out[3:0]];
      nxt_st.r2 = st_ff.ctrl[`CTRL_RELAY_RED] ? pool[st_ff.route_out[3:0]] : pool[st_ff.route_out[7:4]];
      drv = pool[st_ff.route_out[11:8]];
      nxt_st.hs = drv & (st_ff.ctrl[`CTRL_HILO_RED] | ~st_ff.ctrl[`CTRL_HILO_LOW]);
      nxt_st.ls = drv & (st_ff.ctrl[`CTRL_HILO_RED] | st_ff.ctrl[`CTRL_HILO_LOW]);
    end
    nxt_st.fault = ~mon_ok;
    // write side: address and data taken in either order
    if (s_axi_awvalid && st_ff.awrdy)
    begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wrdy)
    begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready)
      nxt_st.bvalid = 1'b0;
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid)
    begin
      wa = {st_ff.aw_addr[7:2], 2'b00};
      wr_ok = 1'b1;
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      unique case (wa)
        `OFS_CTRL:
          nxt_st.ctrl = 7'(merge(32'(st_ff.ctrl), st_ff.wdata, st_ff.wstrb));
        `OFS_AND_MASK:
          nxt_st.and_mask = 12'(merge(32'(st_ff.and_mask), st_ff.wdata, st_ff.wstrb));
        `OFS_OR_MASK:
          nxt_st.or_mask = 12'(merge(32'(st_ff.or_mask), st_ff.wdata, st_ff.wstrb));
        `OFS_ROUTE_CELL:
          nxt_st.route_cell = 24'(merge(32'(st_ff.route_cell), st_ff.wdata, st_ff.wstrb));
        `OFS_ROUTE_OUT:
          nxt_st.route_out = 12'(merge(32'(st_ff.route_out), st_ff.wdata, st_ff.wstrb));
        `OFS_PICKUP:
        begin
          wd = merge(32'(st_ff.pickup), st_ff.wdata, st_ff.wstrb);
          nxt_st.pickup = 9'(clamp(wd, WIN_MIN, WIN_MAX));
        end
        `OFS_DROPOUT:
        begin
          wd = merge(32'(st_ff.dropout), st_ff.wdata, st_ff.wstrb);
          nxt_st.dropout = 9'(clamp(wd, WIN_MIN, WIN_MAX));
        end
        `OFS_TIMER_DELAY:
        begin
          wd = merge(32'(st_ff.tdelay), st_ff.wdata, st_ff.wstrb);
          nxt_st.tdelay = clamp(wd, 1, TMR_MAX);
        end
        default:
          wr_ok = 1'b0;
      endcase
      nxt_st.bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    nxt_st.awrdy = !nxt_st.aw_got && !(s_axi_awvalid && st_ff.awrdy);
    nxt_st.wrdy = !nxt_st.w_got && !(s_axi_wvalid && st_ff.wrdy);
    // read side: one cycle to the data beat
    if (st_ff.rvalid && s_axi_rready)
      nxt_st.rvalid = 1'b0;
    if (s_axi_arvalid && st_ff.arrdy)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = `RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        `OFS_CTRL: nxt_st.rdata = 32'(st_ff.ctrl);
        `OFS_AND_MASK: nxt_st.rdata = 32'(st_ff.and_mask);
        `OFS_OR_MASK: nxt_st.rdata = 32'(st_ff.or_mask);
        `OFS_ROUTE_CELL: nxt_st.rdata = 32'(st_ff.route_cell);
        `OFS_ROUTE_OUT: nxt_st.rdata = 32'(st_ff.route_out);
        `OFS_PICKUP: nxt_st.rdata = 32'(st_ff.pickup);
        `OFS_DROPOUT: nxt_st.rdata = 32'(st_ff.dropout);
        `OFS_TIMER_DELAY: nxt_st.rdata = 32'(st_ff.tdelay);
        `OFS_STATUS: nxt_st.rdata = {15'h0000, st_ff.fault, st_ff.ls, st_ff.hs, st_ff.r2, st_ff.r1, pool};
        default:
        begin
          nxt_st.rdata = 32'h00000000;
          nxt_st.rresp = `RESP_SLVERR;
        end
      endcase
    end
    nxt_st.arrdy = !nxt_st.rvalid;
  end

  // all state in one register; window and timer reset to the shortest delay
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= '0;
      st_ff.ctrl <= `RST_CTRL;
      st_ff.and_mask <= `RST_MASK;
      st_ff.or_mask <= `RST_MASK;
      st_ff.route_cell <= `RST_ROUTE_CELL;
      st_ff.route_out <= `RST_ROUTE_OUT;
      st_ff.pickup <= `RST_WINDOW;
      st_ff.dropout <= `RST_WINDOW;
      st_ff.tdelay <= `RST_TIMER;
      st_ff.rs_q <= 1'b0;
    end
    else
      st_ff <= nxt_st;
  end

  assign s_axi_awready = st_ff.awrdy;
  assign s_axi_wready = st_ff.wrdy;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.arrdy;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign first_relay = st_ff.r1;
  assign second_relay = st_ff.r2;
  assign high_side_switch = st_ff.hs;
  assign low_side_switch = st_ff.ls;
  assign monitor_fault = st_ff.fault;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_redundant_pair;
    (st_ff.tick && st_ff.ctrl[`CTRL_RELAY_RED]) |=> (first_relay == second_relay);
  endproperty
  a_redundant_pair: assert property (p_redundant_pair) else $error("redundant relays differ");
  property p_and_cell;
    st_ff.tick |=> (st_ff.and_q == &($past(pool) | ~$past(st_ff.and_mask)));
  endproperty
  a_and_cell: assert property (p_and_cell) else $error("and cell wrong");
  property p_or_cell;
    st_ff.tick |=> (st_ff.or_q == |($past(pool) & $past(st_ff.or_mask)));
  endproperty
  a_or_cell: assert property (p_or_cell) else $error("or cell wrong");
  property p_not_cell;
    st_ff.tick |=> (st_ff.not_q != $past(pool[st_ff.route_cell[11:8]]));
  endproperty
  a_not_cell: assert property (p_not_cell) else $error("not cell wrong");
  property p_rs_both;
    (st_ff.tick && pool[st_ff.route_cell[15:12]] && pool[st_ff.route_cell[19:16]]) |=> !st_ff.rs_q;
  endproperty
  a_rs_both: assert property (p_rs_both) else $error("storage cell not reset dominant");
  property p_const_one;
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFS_STATUS) |=> s_axi_rdata[`POOL_CONST1];
  endproperty
  a_const_one: assert property (p_const_one) else $error("constant cell not one");
  property p_fault_flag;
    ##1 (monitor_fault == !$past(mon_ok));
  endproperty
  a_fault_flag: assert property (p_fault_flag) else $error("monitor result not mirrored");
  property p_tick_period;
    st_ff.tick |=> !st_ff.tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick longer than one cycle");
endmodule : safety_logic_cells

// >>> testbench/switchgear_model.sv
/*
  external switchgear with positively driven feedback contacts in series;
  assumes coil is the high-low output pair and fail is set by the bench
*/
`timescale 1ns/1ps
module switchgear_model #(
  parameter int LAG = 12
) (
  input wire logic aclk,
  input wire logic coil,
  input wire logic [1:0] fail,
  output logic loop_closed
);
  logic moved = 1'h0;
  int cnt = 0;
  // armature follows the coil only after a mechanical lag
  always @(posedge aclk)
  begin
    if (coil != moved && cnt < LAG)
      cnt <= cnt + 1;
    else
    begin
      cnt <= 0;
      moved <= coil;
    end
  end
  // 1 welded shut, 2 broken open, else closed at rest and open when pulled in
  assign loop_closed = (fail == 2'h1) | ((fail != 2'h2) & ~moved);
endmodule : switchgear_model

// >>> testbench/testbench.sv
/*
  self-checking bench for the safety logic cells over AXI4-Lite;
  assumes a short processing tick of 8 aclk cycles and the switchgear model
*/
`timescale 1ns/1ps
`include "cells_map.svh"
module testbench;
  localparam int TK = 8;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp, rd_resp;
  logic [31:0] s_axi_rdata, rd_data;
  logic [2:0] din = 3'h0;
  logic [1:0] fail = 2'h0;
  logic fb, first_relay, second_relay, high_side_switch, low_side_switch, monitor_fault, b;
  logic [3:0] digital_in;
  logic [2:0] rs_in [5] = '{3'h0, 3'h1, 3'h0, 3'h2, 3'h3};
  logic rs_exp [5] = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h0};
  logic [31:0] modes [3] = '{32'h0, 32'h5, 32'h2};
  int mismatches = 0;
  int compares = 0;
  assign digital_in = {fb, din};
  safety_logic_cells #(.TICK_CYCLES(TK)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .digital_in, .first_relay, .second_relay, .high_side_switch, .low_side_switch, .monitor_fault);
  switchgear_model sg (.aclk(aclk), .coil(high_side_switch | low_side_switch), .fail(fail), .loop_closed(fb));
  // 40 MHz clock
  initial
  begin
    forever #12.5 aclk = ~aclk;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // ticks are fixed by the tick parameter, so plain waits are safe here
  task automatic wt(input int n);
    repeat (n * TK) @(posedge aclk);
  endtask : wt
  task automatic st(input int i, input logic e, input string n);
    rd(`OFS_STATUS);
    check(n, 32'(rd_data[i]), 32'(e));
  endtask : st
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  // watchdog: whole run needs about a thousand cycles
  initial
  begin
    repeat (30000) @(posedge aclk);
    mismatches++;
    summarize();
  end
  // main sequence
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    st(9, 1'h0, "storage init");
    st(4, 1'h1, "const one");
    st(11, 1'h1, "monitor idle ok");
    rd(`OFS_PICKUP);
    check("pickup reset", rd_data, 32'h1);
    rd(`OFS_TIMER_DELAY);
    check("timer reset", rd_data, 32'h1);
    rd(8'h24);
    check("unmapped read", {rd_data[29:0], rd_resp}, {30'h0, `RESP_SLVERR});
    wr(`OFS_STATUS, 32'h1);
    check("status write", 32'(wr_resp), 32'(`RESP_SLVERR));
    wr(`OFS_PICKUP, 32'h190);
    rd(`OFS_PICKUP);
    check("pickup max", rd_data, 32'h177);
    wr(`OFS_DROPOUT, 32'h0);
    rd(`OFS_DROPOUT);
    check("dropout min", rd_data, 32'h1);
    wr(`OFS_AND_MASK, 32'h7);
    wr(`OFS_OR_MASK, 32'h7);
    wr(`OFS_ROUTE_CELL, 32'h210010);
    wr(`OFS_ROUTE_OUT, 32'h040);
    wr(`OFS_TIMER_DELAY, 32'h4);
    wr(`OFS_PICKUP, 32'h3);
    wr(`OFS_DROPOUT, 32'h3);
    for (int v = 0; v < 8; v++)
    begin
      din <= v[2:0];
      wt(3);
      rd(`OFS_STATUS);
      check("cells", 32'(rd_data[8:5]), 32'({~v[0], v[0] ^ v[1], |v[2:0], &v[2:0]}));
    end
    for (int i = 0; i < 5; i++)
    begin
      din <= rs_in[i];
      wt(3);
      st(9, rs_exp[i], "storage");
    end
    din <= 3'h4;
    wt(2);
    st(10, 1'h0, "pickup early");
    wt(4);
    st(10, 1'h1, "pickup done");
    din <= 3'h0;
    wt(2);
    st(10, 1'h0, "pickup fall");
    wr(`OFS_CTRL, 32'h10);
    din <= 3'h4;
    wt(2);
    st(10, 1'h1, "dropout rise");
    wt(4);
    st(10, 1'h0, "dropout expiry");
    for (int m = 0; m < 3; m++)
    begin
      wr(`OFS_CTRL, modes[m]);
      for (int d = 0; d < 2; d++)
      begin
        b = d[0];
        din <= {2'h0, b};
        wt(2);
        check("outputs", 32'({first_relay, second_relay, high_side_switch, low_side_switch}),
          32'({b, modes[m][0] ? b : 1'h1, b & (modes[m][1] | ~modes[m][2]), b & (modes[m][1] | modes[m][2])}));
      end
    end
    // monitor on channel 3 with the high-low pair redundant
    din <= 3'h0;
    // let the armature fall back first: an open loop with the output off faults at once
    wt(3);
    wr(`OFS_CTRL, 32'h6a);
    wt(2);
    din <= 3'h1;
    wt(6);
    check("fault after on", 32'(monitor_fault), 32'h0);
    din <= 3'h0;
    wt(6);
    check("fault after off", 32'(monitor_fault), 32'h0);
    fail <= 2'h1;
    din <= 3'h1;
    wt(6);
    check("welded contact", 32'(monitor_fault), 32'h1);
    st(11, 1'h0, "monitor result");
    wr(`OFS_CTRL, 32'h62);
    fail <= 2'h0;
    wt(3);
    check("monitor disabled", 32'(monitor_fault), 32'h0);
    wr(`OFS_CTRL, 32'h6a);
    wt(2);
    fail <= 2'h2;
    din <= 3'h0;
    wt(6);
    check("broken contact", 32'(monitor_fault), 32'h1);
    summarize();
  end
endmodule : testbench
